// [src/qbp_acc_if.sv]
// Access carrier between the register decoder and the port bank core
`timescale 1ns/1ps
`default_nettype none
interface qbp_acc_if;
	import qbp_pkg::*;
	logic [NUM_PORTS-1:0] wr_sel;
	logic [7:0]           wr_mask;
	logic [7:0]           wr_data;
	logic [NUM_PORTS-1:0] rd_sel;
	logic [2:0]           rd_bit;
	logic                 rd_is_bit;
	logic                 rd_en;

	modport dec
	(
		output wr_sel, wr_mask, wr_data, rd_sel, rd_bit, rd_is_bit, rd_en
	);
	modport core
	(
		input wr_sel, wr_mask, wr_data, rd_sel, rd_bit, rd_is_bit, rd_en
	);
endinterface
`default_nettype wire

// [src/qbp_pin_cell.sv]
// One pin's pull-up, pull-down and strong boost control
`timescale 1ns/1ps
`default_nettype none
module qbp_pin_cell
(
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              present_in,
	input  var  qbp_pkg::qbp_mode_t mode_in,
	input  wire logic              latch_in,
	input  wire logic              pin_in,
	output logic                   pull_down_out,
	output logic                   very_weak_out,
	output logic                   weak_out,
	output logic                   strong_out,
	output logic                   sensed_out
);
	import qbp_pkg::*;

	typedef struct packed {
		logic       prev_latch;
		logic [1:0] boost_cnt;
	} qbp_cell_state_t;

	qbp_cell_state_t st_r;
	qbp_cell_state_t st_nxt;
	logic            quasi;
	logic            rise;

	// ------------------------------------------------------------------
	// Drive
	// ------------------------------------------------------------------
	always_comb
	begin
		quasi         = present_in && (mode_in == QBP_QUASI);
		rise          = quasi && latch_in && !st_r.prev_latch;
		very_weak_out = quasi && latch_in;
		weak_out      = quasi && latch_in && pin_in;
		// Boost starts in the cycle the latch rises, no extra lag
		strong_out    = quasi && latch_in && (rise || (st_r.boost_cnt != 2'h0));
		// Open-drain never pulls up; input-only drives nothing
		pull_down_out = present_in && !latch_in &&
		                ((mode_in == QBP_QUASI) || (mode_in == QBP_OPEN_DRAIN));
		sensed_out    = present_in && pin_in;

		st_nxt            = st_r;
		st_nxt.prev_latch = latch_in;
		if (rise)
			st_nxt.boost_cnt = STRONG_CLKS - 2'h1;
		else if (!quasi || !latch_in)
			st_nxt.boost_cnt = 2'h0;
		else if (st_r.boost_cnt != 2'h0)
			st_nxt.boost_cnt = st_r.boost_cnt - 2'h1;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= '{prev_latch: 1'b1, boost_cnt: 2'h0};
		else
			st_r <= st_nxt;
	end

endmodule // qbp_pin_cell
`default_nettype wire

// [src/qbp_pkg.sv]
// Constants, types and decode helpers for the quasi-bidirectional port bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package qbp_pkg;

	localparam int NUM_PORTS = 5;
	localparam int PORT_W    = 8;
	localparam int NUM_PINS  = NUM_PORTS * PORT_W;

	// Byte addresses; bit addresses of a port start at the same value
	localparam logic [7:0] PORT_ZERO_ADDR  = 8'h80;
	localparam logic [7:0] PORT_ONE_ADDR   = 8'h90;
	localparam logic [7:0] PORT_TWO_ADDR   = 8'ha0;
	localparam logic [7:0] PORT_THREE_ADDR = 8'hb0;
	localparam logic [7:0] PORT_FOUR_ADDR  = 8'he8;

	localparam logic [7:0] LATCH_RST      = 8'hff;
	localparam logic [7:0] FOUR_LATCH_RST = 8'h7f;
	localparam logic [7:0] FULL_MASK      = 8'hff;
	localparam logic [7:0] FOUR_BASE_MASK = 8'h0f;
	localparam logic [7:0] FOUR_EXT_MASK  = 8'h70;

	// Strong pull-up hold, in CPU clocks
	localparam logic [1:0] STRONG_CLKS = 2'h2;

	typedef enum logic [1:0] {
		QBP_QUASI,
		QBP_INPUT_ONLY,
		QBP_OPEN_DRAIN
	} qbp_mode_t;

	// One-hot port select for an address group of eight
	function automatic logic [NUM_PORTS-1:0] qbp_port_sel(input logic [7:0] addr);
		logic [7:0] base;
		base = {addr[7:3], 3'h0};
		qbp_port_sel = {base == PORT_FOUR_ADDR, base == PORT_THREE_ADDR,
		                base == PORT_TWO_ADDR, base == PORT_ONE_ADDR,
		                base == PORT_ZERO_ADDR};
	endfunction

endpackage

// [src/qbp_port_bank.sv]
// Five 8-bit port latches with per-pin mode and pull-up control
`timescale 1ns/1ps
`default_nettype none
module qbp_port_bank
(
	input  wire logic                   sys_clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic [7:0]             sfr_addr_in,
	input  wire logic                   sfr_wr_in,
	input  wire logic                   sfr_rd_in,
	input  wire logic                   sfr_rmw_in,
	input  wire logic [7:0]             sfr_wdata_in,
	input  wire logic [7:0]             bit_addr_in,
	input  wire logic                   bit_wr_in,
	input  wire logic                   bit_rd_in,
	input  wire logic                   bit_wdata_in,
	input  wire logic                   mode_wr_in,
	input  wire logic [2:0]             mode_port_in,
	input  wire logic [2:0]             mode_bit_in,
	input  wire logic [1:0]             mode_val_in,
	input  wire logic                   port_four_ext_in,
	input  wire logic [qbp_pkg::NUM_PINS-1:0] pin_in,
	output logic [7:0]                  sfr_rdata_out,
	output logic                        bit_rdata_out,
	output logic                        rd_valid_out,
	output logic                        port_four_ext_out,
	output logic [qbp_pkg::NUM_PINS-1:0] pin_o_out,
	output logic [qbp_pkg::NUM_PINS-1:0] pin_oe_out,
	output logic [qbp_pkg::NUM_PINS-1:0] pull_down_out,
	output logic [qbp_pkg::NUM_PINS-1:0] very_weak_out,
	output logic [qbp_pkg::NUM_PINS-1:0] weak_out,
	output logic [qbp_pkg::NUM_PINS-1:0] strong_out
);
	import qbp_pkg::*;

	typedef struct packed {
		logic [NUM_PORTS-1:0][7:0]            latch;
		qbp_mode_t [NUM_PORTS-1:0][PORT_W-1:0] mode;
		logic                                 ext;
		logic                                 ext_done;
		logic [7:0]                           rdata;
		logic                                 rbit;
		logic                                 rvalid;
	} qbp_bank_state_t;

	qbp_bank_state_t          st_r;
	qbp_bank_state_t          st_nxt;
	qbp_acc_if                acc ();
	logic [NUM_PORTS-1:0][7:0] impl;
	logic [NUM_PORTS-1:0][7:0] sensed;
	logic [NUM_PINS-1:0]      sensed_flat;
	logic [NUM_PINS-1:0]      sd;
	logic [NUM_PINS-1:0]      su;
	logic [7:0]               rd_byte;
	qbp_mode_t                new_mode;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	qbp_sfr_dec u_dec
	(
		.sfr_addr_in  (sfr_addr_in),
		.sfr_wr_in    (sfr_wr_in),
		.sfr_rd_in    (sfr_rd_in),
		.sfr_wdata_in (sfr_wdata_in),
		.bit_addr_in  (bit_addr_in),
		.bit_wr_in    (bit_wr_in),
		.bit_rd_in    (bit_rd_in),
		.bit_wdata_in (bit_wdata_in),
		.acc          (acc.dec)
	);

	// ------------------------------------------------------------------
	// Implemented bits
	// ------------------------------------------------------------------
	always_comb
	begin
		for (int p = 0; p < NUM_PORTS - 1; p++)
			impl[p] = FULL_MASK;
		// Bit seven never exists; four to six only on the reused-pin variant
		impl[NUM_PORTS-1] = FOUR_BASE_MASK | (st_r.ext ? FOUR_EXT_MASK : 8'h00);
	end

	// ------------------------------------------------------------------
	// Pin cells
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : g_pin
			qbp_pin_cell u_cell
			(
				.sys_clk_in    (sys_clk_in),
				.rst_n_in      (rst_n_in),
				.present_in    (impl[g / PORT_W][g % PORT_W]),
				.mode_in       (st_r.mode[g / PORT_W][g % PORT_W]),
				.latch_in      (st_r.latch[g / PORT_W][g % PORT_W]),
				.pin_in        (pin_in[g]),
				.pull_down_out (sd[g]),
				.very_weak_out (very_weak_out[g]),
				.weak_out      (weak_out[g]),
				.strong_out    (su[g]),
				.sensed_out    (sensed_flat[g])
			);
		end
	endgenerate

	// Only the pull-down and strong stages force the wire; the weak pulls are left to the pad
	always_comb
	begin
		pull_down_out = sd;
		strong_out    = su;
		pin_oe_out    = sd | su;
		pin_o_out     = su;
		sensed        = sensed_flat;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.rvalid = 1'b0;
		new_mode      = qbp_mode_t'(mode_val_in);
		rd_byte       = 8'h00;

		// Strap is sampled once, the first edge after reset release
		if (!st_r.ext_done)
		begin
			st_nxt.ext      = port_four_ext_in;
			st_nxt.ext_done = 1'b1;
		end

		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (acc.wr_sel[p])
				st_nxt.latch[p] = ((st_r.latch[p] & ~acc.wr_mask) | (acc.wr_data & acc.wr_mask)) &
				                  impl[p];
			if (acc.rd_sel[p])
				rd_byte = sfr_rmw_in ? (st_r.latch[p] & impl[p]) : sensed[p];
		end

		// Per-pin mode; unused code and missing ports are ignored
		if (mode_wr_in && (mode_port_in < 3'(NUM_PORTS)) && (mode_val_in != 2'h3))
			st_nxt.mode[mode_port_in][mode_bit_in] = new_mode;

		if (acc.rd_en)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = acc.rd_is_bit ? 8'h00 : rd_byte;
			st_nxt.rbit   = acc.rd_is_bit ? rd_byte[acc.rd_bit] : 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_r          <= '0;
			st_r.latch[0] <= LATCH_RST;
			st_r.latch[1] <= LATCH_RST;
			st_r.latch[2] <= LATCH_RST;
			st_r.latch[3] <= LATCH_RST;
			st_r.latch[4] <= FOUR_LATCH_RST;
			// Element-wise, so each pin keeps its enum type
			for (int b = 0; b < PORT_W; b++)
			begin
				st_r.mode[0][b] <= QBP_OPEN_DRAIN;
				for (int p = 1; p < NUM_PORTS; p++)
					st_r.mode[p][b] <= QBP_QUASI;
			end
		end
		else
			st_r <= st_nxt;
	end

	assign sfr_rdata_out     = st_r.rdata;
	assign bit_rdata_out     = st_r.rbit;
	assign rd_valid_out      = st_r.rvalid;
	assign port_four_ext_out = st_r.ext;

endmodule // qbp_port_bank
`default_nettype wire

// [src/qbp_sfr_dec.sv]
// Byte and bit address decoder for the port latches
`timescale 1ns/1ps
`default_nettype none
module qbp_sfr_dec
(
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic [7:0] bit_addr_in,
	input  wire logic       bit_wr_in,
	input  wire logic       bit_rd_in,
	input  wire logic       bit_wdata_in,
	qbp_acc_if.dec          acc
);
	import qbp_pkg::*;

	logic [NUM_PORTS-1:0] byte_sel;
	logic [NUM_PORTS-1:0] bitg_sel;

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	always_comb
	begin
		byte_sel = (sfr_addr_in[2:0] == 3'h0) ? qbp_port_sel(sfr_addr_in) : '0;
		bitg_sel = qbp_port_sel(bit_addr_in);
		// Byte write wins if the core ever issues both at once
		if (sfr_wr_in)
		begin
			acc.wr_sel  = byte_sel;
			acc.wr_mask = FULL_MASK;
			acc.wr_data = sfr_wdata_in;
		end
		else if (bit_wr_in)
		begin
			acc.wr_sel  = bitg_sel;
			acc.wr_mask = 8'h01 << bit_addr_in[2:0];
			acc.wr_data = {8{bit_wdata_in}};
		end
		else
		begin
			acc.wr_sel  = '0;
			acc.wr_mask = '0;
			acc.wr_data = '0;
		end
		acc.rd_is_bit = bit_rd_in & ~sfr_rd_in;
		acc.rd_en     = sfr_rd_in | bit_rd_in;
		acc.rd_sel    = sfr_rd_in ? byte_sel : (bit_rd_in ? bitg_sel : '0);
		acc.rd_bit    = bit_addr_in[2:0];
	end

endmodule // qbp_sfr_dec
`default_nettype wire

// [verification/qbp_checker.sv]
// Port-level assertions for the port bank
`timescale 1ns/1ps
`default_nettype none
module qbp_checker
(
	input wire logic                         sys_clk_in,
	input wire logic                         rst_n_in,
	input wire logic [7:0]                   sfr_addr_in,
	input wire logic                         sfr_wr_in,
	input wire logic                         sfr_rd_in,
	input wire logic [7:0]                   sfr_wdata_in,
	input wire logic                         bit_rd_in,
	input wire logic [qbp_pkg::NUM_PINS-1:0] pin_in,
	input wire logic [7:0]                   sfr_rdata_out,
	input wire logic                         rd_valid_out,
	input wire logic [qbp_pkg::NUM_PINS-1:0] pin_oe_out,
	input wire logic [qbp_pkg::NUM_PINS-1:0] pull_down_out,
	input wire logic [qbp_pkg::NUM_PINS-1:0] very_weak_out,
	input wire logic [qbp_pkg::NUM_PINS-1:0] weak_out,
	input wire logic [qbp_pkg::NUM_PINS-1:0] strong_out
);
	import qbp_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	weak_cause_a: assert property ((weak_out & ~(very_weak_out & pin_in)) == '0)
		else $error("weak pull-up without cause");
	strong_src_a: assert property ((strong_out & ~very_weak_out) == '0)
		else $error("strong pull-up with latch zero");
	pull_excl_a: assert property ((pull_down_out & very_weak_out) == '0)
		else $error("pull-down fights pull-up");
	oe_drive_a: assert property (pin_oe_out == (pull_down_out | strong_out))
		else $error("output enable mismatch");
	strong_len_a: assert property ((strong_out & $past(strong_out) & $past(strong_out, 2)) == '0)
		else $error("strong pull-up beyond two clocks");
	rd_answer_a: assert property (sfr_rd_in || bit_rd_in |=> rd_valid_out)
		else $error("read not answered");
	unmapped_a: assert property (sfr_rd_in && sfr_addr_in == 8'h88 |=> sfr_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	clr_byte_a: assert property (sfr_wr_in && sfr_addr_in == 8'h90 && sfr_wdata_in == 8'h00
		|=> pull_down_out[15:8] == 8'hff)
		else $error("cleared latch not pulled down");

	cover property ($rose(strong_out[8]));
	cover property (rd_valid_out && sfr_rdata_out == 8'h00);
	cover property (|(weak_out & pin_in));
endmodule // qbp_checker
`default_nettype wire

// [verification/qbp_pin_env.sv]
// Pin-side environment: external pull-ups, pull-low and floating pins
`timescale 1ns/1ps
`default_nettype none
module qbp_pin_env
(
	input  wire logic        sys_clk_in,
	input  wire logic [39:0] o_in,
	input  wire logic [39:0] oe_in,
	input  wire logic [39:0] vw_in,
	input  wire logic [39:0] low_in,
	input  wire logic [39:0] pu_in,
	output logic      [39:0] pin_out
);
	logic flt_r = 1'b0;
	// Floating pins toggle so a stale level never passes as a match
	always @(posedge sys_clk_in)
		flt_r <= ~flt_r;
	always_comb
		for (int i = 0; i < 40; i++)
			pin_out[i] = oe_in[i] ? o_in[i] : low_in[i] ? 1'b0 : (vw_in[i] | pu_in[i]) ? 1'b1 : flt_r;
endmodule // qbp_pin_env
`default_nettype wire

// [verification/qbp_port_bank_tb_top.sv]
// Self-checking bench for the port bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module qbp_port_bank_tb_top;
	import qbp_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} qbp_row_t;
	localparam logic [4:0] MW = 5'h10, BW = 5'h08, RD = 5'h04, TW = 5'h02, TR = 5'h01;
	logic        sys_clk_in, rst_n_in, sfr_wr_in, sfr_rd_in, sfr_rmw_in, bit_wr_in, bit_rd_in, bit_wdata_in;
	logic        mode_wr_in, port_four_ext_in, bit_rdata_out, rd_valid_out, port_four_ext_out;
	logic [7:0]  sfr_addr_in, sfr_wdata_in, bit_addr_in, sfr_rdata_out;
	logic [2:0]  mode_port_in, mode_bit_in;
	logic [1:0]  mode_val_in;
	logic [39:0] pin_in, pin_o_out, pin_oe_out, pull_down_out, very_weak_out, weak_out, strong_out;
	logic [39:0] ext_low, ext_pu;
	int          errors, checked, cyc;
	qbp_row_t    rows [5];

	qbp_port_bank uut (.sys_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_rmw_in, .sfr_wdata_in,
		.bit_addr_in, .bit_wr_in, .bit_rd_in, .bit_wdata_in, .mode_wr_in, .mode_port_in, .mode_bit_in,
		.mode_val_in, .port_four_ext_in, .pin_in, .sfr_rdata_out, .bit_rdata_out, .rd_valid_out,
		.port_four_ext_out, .pin_o_out, .pin_oe_out, .pull_down_out, .very_weak_out, .weak_out, .strong_out);
	qbp_pin_env env (.sys_clk_in, .o_in(pin_o_out), .oe_in(pin_oe_out), .vw_in(very_weak_out),
		.low_in(ext_low), .pu_in(ext_pu), .pin_out(pin_in));

	initial
	begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	task tick;
		@(posedge sys_clk_in);
		#5;
	endtask

	// One request held for one taking edge, then released
	task acc(input logic [4:0] k, input logic [7:0] a, input logic [7:0] d);
		tick();
		{mode_wr_in, sfr_wr_in, sfr_rd_in, bit_wr_in, bit_rd_in} = k;
		{sfr_addr_in, bit_addr_in, sfr_wdata_in, bit_wdata_in} = {a, a, d, d[0]};
		{mode_port_in, mode_bit_in, mode_val_in} = {a[6:4], a[2:0], d[1:0]};
		tick();
		{mode_wr_in, sfr_wr_in, sfr_rd_in, bit_wr_in, bit_rd_in} = 5'h00;
	endtask

	task rst(input logic s);
		rst_n_in = 1'b0;
		port_four_ext_in = s;
		repeat (3) @(posedge sys_clk_in);
		#5;
		rst_n_in = 1'b1;
	endtask

	task summarize;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Run takes about 70 cycles; the ceiling leaves ample slack
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			errors++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial
	begin
		{mode_wr_in, sfr_wr_in, sfr_rd_in, bit_wr_in, bit_rd_in, bit_wdata_in} = 6'h00;
		{sfr_addr_in, sfr_wdata_in, bit_addr_in, mode_port_in, mode_bit_in, mode_val_in} = 32'h0;
		{sfr_rmw_in, ext_low, ext_pu} = {1'b1, 40'h0, 40'hff};
		{errors, checked, cyc} = {32'h0, 32'h0, 32'h0};
		rows = '{'{8'h80, 8'ha5, 8'ha5}, '{8'h90, 8'h3c, 8'h3c}, '{8'ha0, 8'hc3, 8'hc3},
			'{8'hb0, 8'h5a, 8'h5a}, '{8'he8, 8'hff, 8'h0f}};
		rst(1'b0);
		`CHK({pin_oe_out[7:0], very_weak_out[7:0]}, 16'h0000)
		`CHK(very_weak_out[39:8], 32'h0fffffff)
		foreach (rows[i])
		begin
			acc(BW, rows[i].a, rows[i].d);
			acc(RD, rows[i].a, 8'h00);
			`CHK(sfr_rdata_out, rows[i].e)
		end
		sfr_rmw_in = 1'b0;
		acc(RD, 8'hb0, 8'h00);
		`CHK(sfr_rdata_out, 8'h5a)
		// Pin reads up to the final latch read; bit reads follow the same select
		acc(BW, 8'h90, 8'h00);
		`CHK(pin_oe_out[15:8], 8'hff)
		acc(TW, 8'h90, 8'h01);
		`CHK({strong_out[8], pin_o_out[8], pin_oe_out[8]}, 3'h7)
		tick();
		`CHK(strong_out[8], 1'b1)
		tick();
		`CHK({strong_out[8], weak_out[8]}, 2'h1)
		ext_low[8] = 1'b1;
		#1;
		`CHK({weak_out[8], very_weak_out[8]}, 2'h1)
		acc(TR, 8'h90, 8'h00);
		`CHK(bit_rdata_out, 1'b0)
		{ext_low[8], ext_pu[8]} = 2'h1;
		acc(MW, 8'h10, 8'h02);
		`CHK({very_weak_out[8], weak_out[8], pull_down_out[8]}, 3'h0)
		acc(TR, 8'h90, 8'h00);
		`CHK(bit_rdata_out, 1'b1)
		acc(TW, 8'h90, 8'h00);
		`CHK(pull_down_out[8], 1'b1)
		acc(TR, 8'h90, 8'h00);
		`CHK(bit_rdata_out, 1'b0)
		acc(MW, 8'h10, 8'h01);
		`CHK({pin_oe_out[8], pull_down_out[8], very_weak_out[8]}, 3'h0)
		acc(TR, 8'h90, 8'h00);
		`CHK(bit_rdata_out, 1'b1)
		acc(MW, 8'h40, 8'h02);
		`CHK({very_weak_out[32], very_weak_out[9]}, 2'h0)
		acc(RD, 8'h88, 8'h00);
		`CHK({rd_valid_out, sfr_rdata_out}, 9'h100)
		acc(TW, 8'h82, 8'h00);
		acc(TW, 8'h86, 8'h01);
		acc(RD, 8'h80, 8'h00);
		`CHK(sfr_rdata_out, 8'he1)
		rst(1'b1);
		acc(RD, 8'he8, 8'h00);
		`CHK(sfr_rdata_out, 8'h7f)
		for (logic [7:0] b = 8'hec; b < 8'hef; b++)
			acc(TW, b, 8'h00);
		acc(TW, 8'hef, 8'h01);
		sfr_rmw_in = 1'b1;
		acc(RD, 8'he8, 8'h00);
		`CHK({port_four_ext_out, sfr_rdata_out}, 9'h10f)
		summarize();
	end
endmodule // qbp_port_bank_tb_top

bind qbp_port_bank qbp_checker chk (.sys_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
	.sfr_wdata_in, .bit_rd_in, .pin_in, .sfr_rdata_out, .rd_valid_out, .pin_oe_out, .pull_down_out,
	.very_weak_out, .weak_out, .strong_out);
`default_nettype wire
